//--- hcm_capture.sv
/*
 hall synchronisation and capture mode logic for three channels,
 with an axi4-lite register slave.
 assumes: pins arrive asynchronously; timer value and timer events
 come from logic on CLOCK; one write and one read at most in flight.
*/
`timescale 1ns/1ps
module hcm_capture
(
   // clock and reset
   input  wire logic                CLOCK,
   input  wire logic                RESET,
   // pins
   input  wire logic [2:0]          CAP_PIN,
   input  wire logic [2:0]          POS_PIN,
   // timer side
   input  wire logic [15:0]         TIMER_VALUE,
   input  wire hcm_pkg::hcm_tmr_evt_t TIMER_EVT,
   output logic                     TIMER_RESET,
   output logic [2:0]               HALL_PATTERN,
   output logic                     HALL_SAMPLE,
   // axi4-lite
   input  wire logic [7:0]          AWADDR,
   input  wire logic                AWVALID,
   output logic                     AWREADY,
   input  wire logic [31:0]         WDATA,
   input  wire logic [3:0]          WSTRB,
   input  wire logic                WVALID,
   output logic                     WREADY,
   output logic [1:0]               BRESP,
   output logic                     BVALID,
   input  wire logic                BREADY,
   input  wire logic [7:0]          ARADDR,
   input  wire logic                ARVALID,
   output logic                     ARREADY,
   output logic [31:0]              RDATA,
   output logic [1:0]               RRESP,
   output logic                     RVALID,
   input  wire logic                RREADY
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0]  mode_lo_ff;
   logic [7:0]  mode_hi_ff;
   logic [5:0]  flag_ff;
   logic [2:0]  state_ff;
   logic        hall_evt_ff;
   logic [15:0] cap_ff [3];
   logic [15:0] shd_ff [3];
   logic [5:0]  dtc_load_ff;
   logic [5:0]  dtc_ff;
   logic [2:0]  cap_s1_ff, cap_s2_ff, cap_s3_ff;
   logic [2:0]  pos_s1_ff, pos_s2_ff, pos_s3_ff;
   logic [7:0]  awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        aw_ok_ff, w_ok_ff;
   logic        sw_trig_ff;
   logic [2:0]  hall_ff;

   function automatic logic [3:0] mode_of(input logic [7:0] lo, input logic [7:0] hi,
                                          input int n);
      return (n == 0) ? lo[3:0] : (n == 1) ? lo[7:4] : hi[3:0];
   endfunction : mode_of

   // ----------------------------------------------------------------
   // input synchronisers and edges
   // ----------------------------------------------------------------
   // two stage sync
   always_ff @(posedge CLOCK)
   begin
      cap_s1_ff <= CAP_PIN;
      cap_s2_ff <= cap_s1_ff;
      cap_s3_ff <= cap_s2_ff;
      pos_s1_ff <= POS_PIN;
      pos_s2_ff <= pos_s1_ff;
      pos_s3_ff <= pos_s2_ff;
   end

   wire [2:0] cap_rise = cap_s2_ff & ~cap_s3_ff;
   wire [2:0] cap_fall = ~cap_s2_ff & cap_s3_ff;
   wire [2:0] pos_rise = pos_s2_ff & ~pos_s3_ff;
   wire [2:0] pos_fall = ~pos_s2_ff & pos_s3_ff;
   wire       pos_any  = |(pos_rise | pos_fall);

   // ----------------------------------------------------------------
   // hall trigger selection and delay
   // ----------------------------------------------------------------
   wire [2:0] hsync   = mode_hi_ff[hcm_pkg::HSYNC_LSB +: 3];
   wire       bypass  = mode_hi_ff[hcm_pkg::BYPASS_BIT];
   wire       all_hall = (mode_lo_ff[3:0] == hcm_pkg::M_HALL)
                      && (mode_lo_ff[7:4] == hcm_pkg::M_HALL)
                      && (mode_hi_ff[3:0] == hcm_pkg::M_HALL);
   logic      hw_src;
   always_comb
   begin
      case (hsync)
         hcm_pkg::HS_ANY: hw_src = pos_any;
         hcm_pkg::HS_SCM: hw_src = TIMER_EVT.sec_compare;
         hcm_pkg::HS_SPM: hw_src = TIMER_EVT.sec_period;
         hcm_pkg::HS_OFF: hw_src = 1'b0;
         hcm_pkg::HS_MPM: hw_src = TIMER_EVT.period_match & ~TIMER_EVT.count_down;
         hcm_pkg::HS_MOM: hw_src = TIMER_EVT.one_match & TIMER_EVT.count_down;
         hcm_pkg::HS_C0U: hw_src = TIMER_EVT.compare_match[0] & ~TIMER_EVT.count_down;
         hcm_pkg::HS_C0D: hw_src = TIMER_EVT.compare_match[0] & TIMER_EVT.count_down;
         default:         hw_src = 1'b0;
      endcase
   end
   wire       start_src = hw_src | (all_hall & pos_any);
   wire       dtc_run   = (dtc_ff != 6'h00);
   wire       dtc_fire  = (dtc_ff == hcm_pkg::DTC_DONE);
   wire       sample_now = sw_trig_ff | (bypass & start_src) | (~bypass & dtc_fire);
   wire [5:0] nxt_dtc = (~bypass & start_src) ? dtc_load_ff
                      : dtc_run ? dtc_ff - 6'h01 : 6'h00;
   // valid hall event on changed pattern
   wire       hall_valid = sample_now & all_hall & (pos_s2_ff != hall_ff);

   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         dtc_ff       <= 6'h00;
         hall_ff      <= 3'h0;
         HALL_SAMPLE  <= 1'b0;
         HALL_PATTERN <= 3'h0;
         TIMER_RESET  <= 1'b0;
      end
      else
      begin
         dtc_ff       <= nxt_dtc;
         HALL_SAMPLE  <= sample_now;
         TIMER_RESET  <= hall_valid;
         if (sample_now)
         begin
            hall_ff      <= pos_s2_ff;
            HALL_PATTERN <= pos_s2_ff;
         end
      end
   end

   // ----------------------------------------------------------------
   // per channel capture
   // ----------------------------------------------------------------
   logic [5:0] flag_set;
   logic [2:0] st_set, st_clr;
   for (genvar n = 0; n < 3; n++)
   begin : g_ch
      wire [3:0] m  = mode_of(mode_lo_ff, mode_hi_ff, n);
      wire       cr = cap_rise[n];
      wire       cf = cap_fall[n];
      wire       pr = pos_rise[n];
      wire       pf = pos_fall[n];
      wire       is_cap = (m >= hcm_pkg::M_DBL_RF) && (m != 4'hF)
                          && (m != hcm_pkg::M_HYST) && (m != hcm_pkg::M_HALL || n == 0);
      wire to_cap = (m == hcm_pkg::M_DBL_RF && cr) || (m == hcm_pkg::M_MI_RF && cr)
                 || (m == hcm_pkg::M_MI_FR && cf) || (m == hcm_pkg::M_MI_RR && cr)
                 || (m == hcm_pkg::M_MI_FF && cf) || (m == hcm_pkg::M_MI_AA && (cr | cf))
                 || (m == hcm_pkg::M_HALL && n == 0 && hall_valid);
      wire to_shd = (m == hcm_pkg::M_DBL_RF && cf);
      wire pos_evt = (m == hcm_pkg::M_MI_RF && pf) || (m == hcm_pkg::M_MI_FR && pr)
                  || (m == hcm_pkg::M_MI_RR && pr) || (m == hcm_pkg::M_MI_FF && pf)
                  || (m == hcm_pkg::M_MI_AA && (pr | pf));
      wire chain = (m == hcm_pkg::M_DBL_R && cr) || (m == hcm_pkg::M_DBL_F && cf)
                || (m == hcm_pkg::M_DBL_A && (cr | cf));
      // reserved mode has no compare action
      wire is_cmp = !is_cap && (m != 4'hF);
      assign flag_set[2*n]   = (is_cap && m != hcm_pkg::M_HALL && cr)
                             || (is_cmp && TIMER_EVT.compare_match[n] && !TIMER_EVT.count_down);
      assign flag_set[2*n+1] = (is_cap && m != hcm_pkg::M_HALL && cf)
                             || (is_cmp && TIMER_EVT.compare_match[n] && TIMER_EVT.count_down);
      assign st_set[n] = (pos_evt) || (m == hcm_pkg::M_HYST && TIMER_EVT.compare_match[n]
                                       && pos_s2_ff[n]);
      assign st_clr[n] = (m == hcm_pkg::M_HYST && pf);

      always_ff @(posedge CLOCK)
      begin
         if (RESET)
         begin
            cap_ff[n] <= 16'h0000;
            shd_ff[n] <= 16'h0000;
         end
         else if (chain)
         begin
            cap_ff[n] <= shd_ff[n];
            shd_ff[n] <= TIMER_VALUE;
         end
         else
         begin
            if (to_cap)
               cap_ff[n] <= TIMER_VALUE;
            if (to_shd | pos_evt)
               shd_ff[n] <= TIMER_VALUE;
         end
      end
   end

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   wire do_wr = aw_ok_ff & w_ok_ff & ~BVALID;
   wire do_rd = ARVALID & ARREADY;
   wire wr_hit = (awaddr_ff == hcm_pkg::OFS_MODE_LOW) || (awaddr_ff == hcm_pkg::OFS_MODE_HIGH)
              || (awaddr_ff == hcm_pkg::OFS_STATUS_CL) || (awaddr_ff == hcm_pkg::OFS_CTRL)
              || (awaddr_ff == hcm_pkg::OFS_DTC_LOAD);
   wire wr_b0 = do_wr & wstrb_ff[0];
   wire [3:0] ra_idx = ARADDR[5:2] - 4'h8;
   logic [31:0] rd_mux;
   logic        rd_ok;
   always_comb
   begin
      rd_ok  = 1'b1;
      rd_mux = 32'h0000_0000;
      case (ARADDR)
         hcm_pkg::OFS_MODE_LOW:  rd_mux = {24'h0, mode_lo_ff};
         hcm_pkg::OFS_MODE_HIGH: rd_mux = {24'h0, mode_hi_ff};
         hcm_pkg::OFS_STATUS:    rd_mux = {20'h0, hall_evt_ff, state_ff, 2'h0, flag_ff};
         hcm_pkg::OFS_STATUS_CL: rd_mux = 32'h0000_0000;
         hcm_pkg::OFS_CTRL:      rd_mux = 32'h0000_0000;
         hcm_pkg::OFS_DTC_LOAD:  rd_mux = {26'h0, dtc_load_ff};
         hcm_pkg::OFS_HALL:      rd_mux = {29'h0, hall_ff};
         8'h20, 8'h28, 8'h30:    rd_mux = {16'h0, cap_ff[ra_idx[2:1]]};
         8'h24, 8'h2C, 8'h34:    rd_mux = {16'h0, shd_ff[ra_idx[2:1]]};
         default:                rd_ok = 1'b0;
      endcase
   end
   wire [15:0] clr = (wr_b0 && awaddr_ff == hcm_pkg::OFS_STATUS_CL) ? wdata_ff[15:0] : 16'h0;
   wire [5:0]  nxt_flag  = (flag_ff & ~clr[5:0]) | flag_set;
   wire [2:0]  nxt_state = ((state_ff & ~clr[10:8]) & ~st_clr) | (st_set & ~st_clr);
   wire        nxt_hevt  = (hall_evt_ff & ~clr[hcm_pkg::HALL_EVT_BIT]) | hall_valid;

   always_ff @(posedge CLOCK)
   begin
      if (RESET)
      begin
         mode_lo_ff  <= hcm_pkg::MODE_RESET;
         mode_hi_ff  <= hcm_pkg::MODE_RESET;
         dtc_load_ff <= hcm_pkg::DTC_RESET;
         flag_ff     <= 6'h00;
         state_ff    <= 3'h0;
         hall_evt_ff <= 1'b0;
         sw_trig_ff  <= 1'b0;
         aw_ok_ff    <= 1'b0;
         w_ok_ff     <= 1'b0;
         awaddr_ff   <= 8'h00;
         wdata_ff    <= 32'h0000_0000;
         wstrb_ff    <= 4'h0;
         AWREADY     <= 1'b0;
         WREADY      <= 1'b0;
         BVALID      <= 1'b0;
         BRESP       <= hcm_pkg::RESP_OKAY;
         ARREADY     <= 1'b0;
         RVALID      <= 1'b0;
         RDATA       <= 32'h0000_0000;
         RRESP       <= hcm_pkg::RESP_OKAY;
      end
      else
      begin
         flag_ff     <= nxt_flag;
         state_ff    <= nxt_state;
         hall_evt_ff <= nxt_hevt;
         AWREADY     <= ~aw_ok_ff & ~AWREADY & ~BVALID;
         WREADY      <= ~w_ok_ff & ~WREADY & ~BVALID;
         if (AWVALID & AWREADY)
         begin
            aw_ok_ff  <= 1'b1;
            awaddr_ff <= AWADDR;
         end
         if (WVALID & WREADY)
         begin
            w_ok_ff  <= 1'b1;
            wdata_ff <= WDATA;
            wstrb_ff <= WSTRB;
         end
         sw_trig_ff <= wr_b0 && awaddr_ff == hcm_pkg::OFS_CTRL
                       && wdata_ff[hcm_pkg::SWTRIG_BIT];
         if (wr_b0 && awaddr_ff == hcm_pkg::OFS_MODE_LOW)
            mode_lo_ff <= wdata_ff[7:0];
         if (wr_b0 && awaddr_ff == hcm_pkg::OFS_MODE_HIGH)
            mode_hi_ff <= wdata_ff[7:0];
         if (wr_b0 && awaddr_ff == hcm_pkg::OFS_DTC_LOAD)
            dtc_load_ff <= wdata_ff[5:0];
         if (do_wr)
         begin
            aw_ok_ff <= 1'b0;
            w_ok_ff  <= 1'b0;
            BVALID   <= 1'b1;
            BRESP    <= wr_hit ? hcm_pkg::RESP_OKAY : hcm_pkg::RESP_SLVERR;
         end
         else if (BVALID & BREADY)
            BVALID <= 1'b0;
         ARREADY <= ~RVALID & ~do_rd;
         if (do_rd)
         begin
            RVALID <= 1'b1;
            RDATA  <= rd_mux;
            RRESP  <= rd_ok ? hcm_pkg::RESP_OKAY : hcm_pkg::RESP_SLVERR;
         end
         else if (RVALID & RREADY)
            RVALID <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   a_any_edge_samples: assert property (hsync == hcm_pkg::HS_ANY && bypass && pos_any
      |=> HALL_SAMPLE) else $error("position edge did not sample");
   a_off_no_hw: assert property (hsync == hcm_pkg::HS_OFF && !sw_trig_ff && dtc_ff == 6'h00
      && !all_hall |=> !HALL_SAMPLE) else $error("sample while triggers off");
   a_sw_trigger: assert property (sw_trig_ff |=> HALL_SAMPLE)
      else $error("software trigger lost");
   a_delay_fire: assert property (!bypass && dtc_ff == hcm_pkg::DTC_DONE |=> HALL_SAMPLE)
      else $error("delay end did not sample");
   a_delay_start: assert property (!bypass && start_src |=> dtc_ff == $past(dtc_load_ff))
      else $error("delay counter not loaded");
   a_rise_flag: assert property (mode_of(mode_lo_ff, mode_hi_ff, 1) == hcm_pkg::M_MI_AA
      && cap_rise[1] |=> flag_ff[2]) else $error("rise flag missed");
   a_chain_shift: assert property (mode_lo_ff[3:0] == hcm_pkg::M_DBL_R && cap_rise[0]
      |=> cap_ff[0] == $past(shd_ff[0]) && shd_ff[0] == $past(TIMER_VALUE))
      else $error("shadow chain wrong");
   a_hyst_clear: assert property (mode_lo_ff[3:0] == hcm_pkg::M_HYST && pos_fall[0]
      |=> !state_ff[0]) else $error("state not cleared");
   a_hall_reset: assert property (hall_valid |=> TIMER_RESET && cap_ff[0] == $past(TIMER_VALUE))
      else $error("hall event not captured");
   c_hall_event: cover property (hall_valid);
   c_chain: cover property (mode_lo_ff[3:0] == hcm_pkg::M_DBL_A && cap_fall[0]);
   c_delay: cover property (dtc_fire);
   c_state: cover property (st_set[2]);

endmodule : hcm_capture

//--- hcm_capture_tb_top.sv
/*
 testbench for the hall capture mode block.
 assumes: axi4-lite master tasks, pin model, one 100 MHz clock.
*/
`timescale 1ns/1ps
module hcm_capture_tb_top;
   logic                   CLOCK, RESET;
   logic [2:0]             cap_lvl, pos_lvl, cap_pin, pos_pin, hall_pat;
   logic [15:0]            tval;
   hcm_pkg::hcm_tmr_evt_t  evt;
   logic                   timer_reset, hall_sample;
   logic [7:0]             awaddr, araddr;
   logic [31:0]            wdata, rdata;
   logic [3:0]             wstrb;
   logic [1:0]             bresp, rresp;
   logic [1:0]             wr_exp;
   logic                   awvalid, awready, wvalid, wready, bvalid, bready;
   logic                   arvalid, arready, rvalid, rready;
   int                     bad_count, checks, cyc, samp_n, samp_t, ev_t, tr_cnt;
   int                     lat, i, s, k, md, stm;
   int                     kf[8] = '{-1, 0, 1, -1, 2, 3, 4, 5};
   int                     cap_e[10] = '{5, 1, 0, 2, 5, 2, 5, 2, 5, 0};
   int                     shd_e[10] = '{2, 5, 2, 5, 4, 3, 3, 4, 4, 0};

   hcm_pin_src hcm_pin_src_i (.cap_lvl(cap_lvl), .pos_lvl(pos_lvl),
      .cap_pin(cap_pin), .pos_pin(pos_pin));
   hcm_capture hcm_capture_i (.CLOCK(CLOCK), .RESET(RESET), .CAP_PIN(cap_pin),
      .POS_PIN(pos_pin), .TIMER_VALUE(tval), .TIMER_EVT(evt),
      .TIMER_RESET(timer_reset), .HALL_PATTERN(hall_pat), .HALL_SAMPLE(hall_sample),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
      .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
      .RREADY(rready));

   // ----------------------------------------------------------------
   // clock and pulse monitor
   // ----------------------------------------------------------------
   initial
   begin
      CLOCK = 1'b0;
      forever #5 CLOCK = ~CLOCK;
   end

   always @(posedge CLOCK)
   begin
      cyc <= cyc + 1;
      if (hall_sample === 1'b1)
      begin
         samp_n <= samp_n + 1;
         samp_t <= cyc;
      end
      if (timer_reset === 1'b1) tr_cnt <= tr_cnt + 1;
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic results();
      if (bad_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge CLOCK);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge CLOCK);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      bready <= 1'b0;
      if (n == 64) bad_count++;
      if (n == 64) results();
      chk({30'h0, bresp}, {30'h0, wr_exp});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m, input logic [1:0] r);
      int n;
      @(posedge CLOCK);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge CLOCK);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      rready <= 1'b0;
      if (n == 64) bad_count++;
      if (n == 64) results();
      chk(rdata & m, e);
      chk({30'h0, rresp}, {30'h0, r});
   endtask : rd

   task automatic pin(input logic [2:0] c, input logic [2:0] p, input logic [15:0] t);
      @(posedge CLOCK);
      tval <= t;
      cap_lvl <= c;
      pos_lvl <= p;
      repeat (8) @(posedge CLOCK);
   endtask : pin

   task automatic pulse(input int n);
      hcm_pkg::hcm_tmr_evt_t e;
      e = '0;
      e.count_down = (n == 3 || n == 5);
      e.sec_compare = (n == 0);
      e.sec_period = (n == 1);
      e.period_match = (n == 2);
      e.one_match = (n == 3);
      e.compare_match[0] = (n >= 4);
      @(posedge CLOCK);
      evt <= e;
      ev_t <= cyc;
      @(posedge CLOCK);
      evt <= '0;
   endtask : pulse

   task automatic rst();
      @(posedge CLOCK);
      RESET <= 1'b1;
      cap_lvl <= 3'h0;
      pos_lvl <= 3'h0;
      repeat (20) @(posedge CLOCK);
      RESET <= 1'b0;
      repeat (8) @(posedge CLOCK);
   endtask : rst

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      RESET = 1'b1;
      {cap_lvl, pos_lvl, tval, evt, awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      wr_exp = hcm_pkg::RESP_OKAY;
      {bad_count, checks, cyc, samp_n, samp_t, ev_t, tr_cnt, lat} = '0;
      rst();
      rd(hcm_pkg::OFS_MODE_LOW, 32'h0, '1, hcm_pkg::RESP_OKAY);
      rd(hcm_pkg::OFS_MODE_HIGH, 32'h0, '1, hcm_pkg::RESP_OKAY);
      rd(8'hFC, 32'h0, '1, hcm_pkg::RESP_SLVERR);
      wr_exp = hcm_pkg::RESP_SLVERR;
      wr(8'hFC, 32'h0);
      wr_exp = hcm_pkg::RESP_OKAY;
      for (i = 0; i < 10; i++)
      begin
         md = (i < 4) ? i + 4 : i + 6;
         rst();
         wr(hcm_pkg::OFS_MODE_LOW, md);
         pin(3'h1, 3'h0, 16'h1111);
         pin(3'h0, 3'h0, 16'h2222);
         pin(3'h0, 3'h1, 16'h3333);
         pin(3'h0, 3'h0, 16'h4444);
         pin(3'h1, 3'h0, 16'h5555);
         pulse(4);
         rd(hcm_pkg::OFS_CAP0, cap_e[i] * 32'h1111, '1, 2'h0);
         rd(hcm_pkg::OFS_SHD0, shd_e[i] * 32'h1111, '1, 2'h0);
         stm = (md == 15) ? 0 : ((md > 9) ? 32'h103 : 32'h3);
         rd(hcm_pkg::OFS_STATUS, stm, 32'h103, 2'h0);
         wr(hcm_pkg::OFS_STATUS_CL, 32'h103);
         rd(hcm_pkg::OFS_STATUS, 32'h0, 32'h103, 2'h0);
      end
      rst();
      for (s = 0; s < 8; s++)
      begin
         wr(hcm_pkg::OFS_MODE_HIGH, 32'h80 | (s << 4));
         for (k = 0; k < 6; k++)
         begin
            samp_n = 0;
            pulse(k);
            repeat (6) @(posedge CLOCK);
            chk(samp_n, (kf[s] == k) ? 1 : 0);
            if (s == 1 && k == 0) lat = samp_t - ev_t;
         end
         samp_n = 0;
         pin(3'h0, pos_lvl ^ 3'h1, 16'h0);
         chk(samp_n, (s == 0) ? 1 : 0);
         samp_n = 0;
         wr(hcm_pkg::OFS_CTRL, 32'h1);
         repeat (6) @(posedge CLOCK);
         chk(samp_n, 1);
      end
      wr(hcm_pkg::OFS_DTC_LOAD, 32'h5);
      wr(hcm_pkg::OFS_MODE_HIGH, 32'h10);
      samp_n = 0;
      pulse(0);
      repeat (12) @(posedge CLOCK);
      chk(samp_n, 1);
      chk(samp_t - ev_t - lat, 5);
      rst();
      wr(hcm_pkg::OFS_MODE_LOW, 32'h88);
      wr(hcm_pkg::OFS_MODE_HIGH, 32'h38);
      samp_n = 0;
      tr_cnt = 0;
      pin(3'h0, 3'h1, 16'h0ABC);
      repeat (8) @(posedge CLOCK);
      chk(samp_n, 1);
      chk(tr_cnt, 1);
      chk({29'h0, hall_pat}, 32'h1);
      rd(hcm_pkg::OFS_CAP0, 32'h0ABC, '1, 2'h0);
      rst();
      wr(hcm_pkg::OFS_MODE_LOW, 32'h9);
      pin(3'h0, 3'h1, 16'h0);
      pulse(4);
      pulse(5);
      rd(hcm_pkg::OFS_STATUS, 32'h103, 32'h103, 2'h0);
      pin(3'h0, 3'h0, 16'h0);
      pulse(4);
      rd(hcm_pkg::OFS_STATUS, 32'h3, 32'h103, 2'h0);
      results();
   end
endmodule : hcm_capture_tb_top

//--- hcm_pin_src.sv
/*
 pin source model: hall sensors and capture signal sources.
 assumes: the bench requests levels; pins move off the clock edge.
*/
`timescale 1ns/1ps
module hcm_pin_src
(
   // requested levels
   input  wire logic [2:0] cap_lvl,
   input  wire logic [2:0] pos_lvl,
   // pins
   output logic      [2:0] cap_pin,
   output logic      [2:0] pos_pin
);
   // ----------------------------------------------------------------
   // pins change 3 ns after the request, unrelated to the sample edge
   // ----------------------------------------------------------------
   assign #3 cap_pin = cap_lvl;
   assign #3 pos_pin = pos_lvl;
endmodule : hcm_pin_src

//--- hcm_pkg.sv
/*
 package for the hall capture mode block: register map, field layout,
 reset values, mode codes and structs.
 assumes: one 100 MHz clock, axi4-lite slave with 32-bit data.
*/
package hcm_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_MODE_LOW  = 8'h00;
   localparam logic [7:0] OFS_MODE_HIGH = 8'h04;
   localparam logic [7:0] OFS_STATUS    = 8'h08;
   localparam logic [7:0] OFS_STATUS_CL = 8'h0C;
   localparam logic [7:0] OFS_CTRL      = 8'h10;
   localparam logic [7:0] OFS_CAP0      = 8'h20;
   localparam logic [7:0] OFS_SHD0      = 8'h24;
   localparam logic [7:0] OFS_DTC_LOAD  = 8'h40;
   localparam logic [7:0] OFS_HALL      = 8'h44;

   // ----------------------------------------------------------------
   // fields and reset values
   // ----------------------------------------------------------------
   localparam int          HSYNC_LSB      = 4;
   localparam int          BYPASS_BIT     = 7;
   localparam int          SWTRIG_BIT     = 0;
   localparam int          STATE_LSB      = 8;
   localparam int          HALL_EVT_BIT   = 11;
   localparam logic [7:0]  MODE_RESET     = 8'h00;
   localparam logic [5:0]  DTC_RESET      = 6'h04;
   localparam logic [5:0]  DTC_DONE       = 6'h01;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   // ----------------------------------------------------------------
   // mode codes
   // ----------------------------------------------------------------
   localparam logic [3:0] M_DBL_RF   = 4'h4;
   localparam logic [3:0] M_DBL_R    = 4'h5;
   localparam logic [3:0] M_DBL_F    = 4'h6;
   localparam logic [3:0] M_DBL_A    = 4'h7;
   localparam logic [3:0] M_HALL     = 4'h8;
   localparam logic [3:0] M_HYST     = 4'h9;
   localparam logic [3:0] M_MI_RF    = 4'hA;
   localparam logic [3:0] M_MI_FR    = 4'hB;
   localparam logic [3:0] M_MI_RR    = 4'hC;
   localparam logic [3:0] M_MI_FF    = 4'hD;
   localparam logic [3:0] M_MI_AA    = 4'hE;

   localparam logic [2:0] HS_ANY     = 3'h0;
   localparam logic [2:0] HS_SCM     = 3'h1;
   localparam logic [2:0] HS_SPM     = 3'h2;
   localparam logic [2:0] HS_OFF     = 3'h3;
   localparam logic [2:0] HS_MPM     = 3'h4;
   localparam logic [2:0] HS_MOM     = 3'h5;
   localparam logic [2:0] HS_C0U     = 3'h6;
   localparam logic [2:0] HS_C0D     = 3'h7;

   // ----------------------------------------------------------------
   // timer event carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       count_down;
      logic       period_match;
      logic       one_match;
      logic [2:0] compare_match;
      logic       sec_compare;
      logic       sec_period;
   } hcm_tmr_evt_t;

endpackage : hcm_pkg
